// ===== dcpi_core.v
// Device-side command, address, clock-enable, mask and termination pin logic.
// What this block does
// - Row on activate, column on read/write.
// - Address bit ten is auto precharge.
// - Precharge one bank, or all when bit ten.
// - Load mode takes op-code from address.
// - Bank inputs select target bank.
// - Bank inputs select one of four mode registers.
// - Inputs sampled on rising clock crossing.
// - Output data referenced to clock crossings.
// - Registered clock enable gates internal clocking.
// - Low enable: precharge/self refresh or active power-down.
// - Self refresh exit recognised asynchronously.
// - Power-down and self refresh disable command receivers; termination receiver stays live in power-down.
// - Chip select high masks every command.
// - Command decoded from four control signals.
// - High mask discards that byte of the write beat.
// - Lower mask low byte, upper mask high byte.
// - Registered termination high enables termination.
// - Termination input ignored when mode disables it.
// - Data bus four, eight or sixteen wide.
// - Read strobe edge-aligned; complement only when enabled.
`default_nettype none
`include "dcpi_defines.vh"
module dcpi_core (
	input wire clk_i,
	input wire rst_n_i,
	input wire ce_i,
	input wire [1:0] cfg_width_i,
	input wire cke_pin_i,
	input wire cs_n_pin_i,
	input wire ras_n_pin_i,
	input wire cas_n_pin_i,
	input wire we_n_pin_i,
	input wire odt_pin_i,
	input wire [`DCPI_BANK_W-1:0] ba_pin_i,
	input wire [`DCPI_ADDR_W-1:0] addr_pin_i,
	input wire [1:0] dm_pin_i,
	input wire [`DCPI_DQ_W-1:0] dq_pin_i,
	input wire [`DCPI_DQ_W-1:0] rd_data_i,
	input wire rd_valid_i,
	output reg [`DCPI_DQ_W-1:0] dq_o,
	output reg [`DCPI_DQ_W-1:0] dq_oe_o,
	output reg dqs_o,
	output reg dqs_n_o,
	output reg dqs_oe_o,
	output reg dqs_n_oe_o,
	output reg [2:0] cmd_o,
	output reg cmd_valid_o,
	output reg [`DCPI_BANK_W-1:0] bank_o,
	output reg [`DCPI_ADDR_W-1:0] row_o,
	output reg [`DCPI_ADDR_W-1:0] col_o,
	output reg auto_pre_o,
	output reg [`DCPI_NBANK-1:0] bank_open_o,
	output reg [1:0] power_state_o,
	output reg clk_gate_en_o,
	output reg odt_on_o,
	output reg [`DCPI_DQ_W-1:0] term_en_o,
	output reg [`DCPI_DQ_W-1:0] wr_data_o,
	output reg [`DCPI_DQ_W-1:0] wr_bit_en_o,
	output reg wr_valid_o,
	output reg [`DCPI_ADDR_W-1:0] mr_base_o,
	output reg [`DCPI_ADDR_W-1:0] mr_ext_o,
	output reg [`DCPI_ADDR_W-1:0] mr_ext2_o,
	output reg [`DCPI_ADDR_W-1:0] mr_ext3_o
);
	// Synchronised pin levels.
	wire [`DCPI_ADDR_W+`DCPI_BANK_W+`DCPI_DQ_W+7:0] pin_raw;
	wire [`DCPI_ADDR_W+`DCPI_BANK_W+`DCPI_DQ_W+7:0] pin_s;
	wire cke_s;
	wire cs_n_s;
	wire ras_n_s;
	wire cas_n_s;
	wire we_n_s;
	wire odt_s;
	wire [`DCPI_BANK_W-1:0] ba_s;
	wire [`DCPI_ADDR_W-1:0] addr_s;
	wire [1:0] dm_s;
	wire [`DCPI_DQ_W-1:0] dq_s;
	reg cke_prev_r;
	reg [2:0] cmd_dec;
	reg [`DCPI_DQ_W-1:0] width_mask;
	reg [`DCPI_DQ_W-1:0] keep_mask;
	reg [`DCPI_NBANK-1:0] bank_open_nxt;
	reg [1:0] power_nxt;
	reg wr_pending_r;
	wire rx_cmd_on;
	wire rx_odt_on;
	wire odt_allowed;
	wire [`DCPI_ADDR_W-1:0] mr_ext_nxt;
	wire dqs_diff;
	wire [`DCPI_DQ_W-1:0] dm_bits;
	wire [2:0] cmd_eff;
	genvar gi;

	// All address and control pins are sampled on the rising clock edge.
	assign pin_raw = {cke_pin_i, cs_n_pin_i, ras_n_pin_i, cas_n_pin_i, we_n_pin_i, odt_pin_i,
		ba_pin_i, addr_pin_i, dm_pin_i, dq_pin_i};
	dcpi_sync2 #(
		.W(`DCPI_ADDR_W+`DCPI_BANK_W+`DCPI_DQ_W+8)
	) u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.d_i(pin_raw),
		.q_o(pin_s)
	);
	assign {cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, odt_s, ba_s, addr_s, dm_s, dq_s} = pin_s;

	// Receivers are live only in normal operation; termination control also in power-down.
	assign rx_cmd_on = (power_state_o == `DCPI_PW_NORMAL);
	assign rx_odt_on = (power_state_o == `DCPI_PW_NORMAL) || (power_state_o == `DCPI_PW_PRE_PD)
		|| (power_state_o == `DCPI_PW_ACT_PD);
	// A load of the extended mode register governs termination from the same edge, so no stale cycle.
	assign mr_ext_nxt = (cmd_eff == `DCPI_CMD_LMR && ba_s[1:0] == `DCPI_MR_EXT) ? addr_s : mr_ext_o;
	// Termination is allowed only when the extended mode register enables a value.
	assign odt_allowed = mr_ext_nxt[`DCPI_EMR_RTT_LO] | mr_ext_nxt[`DCPI_EMR_RTT_HI];
	// Complementary strobe only when differential mode is on (bit low enables it).
	assign dqs_diff = ~mr_ext_o[`DCPI_EMR_DQSN_BIT];

	// Command decode from chip select, row, column and write strobes.
	always @*
	begin
		cmd_dec = `DCPI_CMD_NOP;
		if (!cs_n_s)
		begin
			case ({ras_n_s, cas_n_s, we_n_s})
				3'h0: cmd_dec = `DCPI_CMD_LMR;
				3'h1: cmd_dec = `DCPI_CMD_REF;
				3'h2: cmd_dec = `DCPI_CMD_PRE;
				3'h3: cmd_dec = `DCPI_CMD_ACT;
				3'h4: cmd_dec = `DCPI_CMD_WR;
				3'h5: cmd_dec = `DCPI_CMD_RD;
				3'h6: cmd_dec = `DCPI_CMD_BST;
				default: cmd_dec = `DCPI_CMD_NOP;
			endcase
		end
	end
	assign cmd_eff = (rx_cmd_on && clk_gate_en_o) ? cmd_dec : `DCPI_CMD_NOP;

	// Bank state follows activate and precharge.
	always @*
	begin
		bank_open_nxt = bank_open_o;
		case (cmd_eff)
			`DCPI_CMD_ACT: bank_open_nxt[ba_s] = 1'b1;
			`DCPI_CMD_PRE:
			begin
				if (addr_s[`DCPI_AP_BIT])
					bank_open_nxt = {`DCPI_NBANK{1'b0}};
				else
					bank_open_nxt[ba_s] = 1'b0;
			end
			default: bank_open_nxt = bank_open_o;
		endcase
	end

	// Power state from registered clock enable and bank state.
	always @*
	begin
		power_nxt = power_state_o;
		case (power_state_o)
			`DCPI_PW_NORMAL:
			begin
				if (!cke_s && cke_prev_r)
				begin
					if (|bank_open_o)
						power_nxt = `DCPI_PW_ACT_PD;
					else if (cmd_dec == `DCPI_CMD_REF)
						power_nxt = `DCPI_PW_SELF;
					else
						power_nxt = `DCPI_PW_PRE_PD;
				end
			end
			`DCPI_PW_PRE_PD: if (cke_s) power_nxt = `DCPI_PW_NORMAL;
			`DCPI_PW_ACT_PD: if (cke_s) power_nxt = `DCPI_PW_NORMAL;
			`DCPI_PW_SELF: if (cke_pin_i) power_nxt = `DCPI_PW_NORMAL;
			default: power_nxt = `DCPI_PW_NORMAL;
		endcase
	end

	// Width mask and per-bit write enable from the byte masks.
	always @*
	begin
		case (cfg_width_i)
			`DCPI_CFG_X4: width_mask = 16'h000F;
			`DCPI_CFG_X8: width_mask = 16'h00FF;
			default: width_mask = 16'hFFFF;
		endcase
	end
	generate
		for (gi = 0; gi < `DCPI_DQ_W; gi = gi + 1)
		begin : g_mask
			assign dm_bits[gi] = (gi < 8) ? dm_s[0] : dm_s[1];
		end
	endgenerate
	always @*
	begin
		keep_mask = width_mask & ~dm_bits;
	end

	// Main registered state.
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cke_prev_r <= 1'b0;
			clk_gate_en_o <= 1'b0;
			power_state_o <= `DCPI_PW_NORMAL;
			bank_open_o <= 8'h00;
			cmd_o <= `DCPI_CMD_NOP;
			cmd_valid_o <= 1'b0;
			bank_o <= 3'h0;
			row_o <= 14'h0000;
			col_o <= 14'h0000;
			auto_pre_o <= 1'b0;
			mr_base_o <= 14'h0000;
			mr_ext_o <= 14'h0000;
			mr_ext2_o <= 14'h0000;
			mr_ext3_o <= 14'h0000;
			odt_on_o <= 1'b0;
			term_en_o <= 16'h0000;
			wr_pending_r <= 1'b0;
			wr_data_o <= 16'h0000;
			wr_bit_en_o <= 16'h0000;
			wr_valid_o <= 1'b0;
			dq_o <= 16'h0000;
			dq_oe_o <= 16'h0000;
			dqs_o <= 1'b0;
			dqs_n_o <= 1'b1;
			dqs_oe_o <= 1'b0;
			dqs_n_oe_o <= 1'b0;
		end
		else if (ce_i)
		begin
			cke_prev_r <= cke_s;
			clk_gate_en_o <= cke_s;
			power_state_o <= power_nxt;
			bank_open_o <= bank_open_nxt;
			cmd_o <= cmd_eff;
			cmd_valid_o <= (cmd_eff != `DCPI_CMD_NOP);
			if (cmd_eff != `DCPI_CMD_NOP)
				bank_o <= ba_s;
			if (cmd_eff == `DCPI_CMD_ACT)
				row_o <= addr_s;
			if (cmd_eff == `DCPI_CMD_RD || cmd_eff == `DCPI_CMD_WR)
			begin
				col_o <= {addr_s[13:11], 1'b0, addr_s[9:0]};
				auto_pre_o <= addr_s[`DCPI_AP_BIT];
			end
			if (cmd_eff == `DCPI_CMD_LMR)
			begin
				case (ba_s[1:0])
					`DCPI_MR_BASE: mr_base_o <= addr_s;
					`DCPI_MR_EXT: mr_ext_o <= addr_s;
					`DCPI_MR_EXT2: mr_ext2_o <= addr_s;
					default: mr_ext3_o <= addr_s;
				endcase
			end
			// Termination follows the registered pin while allowed and its receiver is live.
			if (rx_odt_on)
				odt_on_o <= odt_s & odt_allowed;
			term_en_o <= (rx_odt_on ? (odt_s & odt_allowed) : odt_on_o) ? width_mask : 16'h0000;
			// Write data captured one cycle after the write command, masked beats dropped.
			wr_pending_r <= (cmd_eff == `DCPI_CMD_WR);
			wr_valid_o <= wr_pending_r && (|keep_mask);
			wr_data_o <= dq_s & width_mask;
			wr_bit_en_o <= wr_pending_r ? keep_mask : 16'h0000;
			// Read data launched on the clock edge with an edge-aligned strobe.
			dq_o <= rd_data_i & width_mask;
			dq_oe_o <= (rd_valid_i && clk_gate_en_o) ? width_mask : 16'h0000;
			dqs_o <= rd_valid_i & ~dqs_o;
			dqs_n_o <= ~(rd_valid_i & ~dqs_o);
			dqs_oe_o <= rd_valid_i & clk_gate_en_o;
			dqs_n_oe_o <= rd_valid_i & clk_gate_en_o & dqs_diff;
		end
	end
endmodule // dcpi_core
`default_nettype wire

// ===== dcpi_core_assertions.sv
// Concurrent checks on the ports of the command pin interface core.
`default_nettype none
module dcpi_core_assertions (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic cs_n_pin_i,
	input wire logic ras_n_pin_i,
	input wire logic cas_n_pin_i,
	input wire logic we_n_pin_i,
	input wire logic [2:0] ba_pin_i,
	input wire logic [13:0] addr_pin_i,
	input wire logic [1:0] dm_pin_i,
	input wire logic [1:0] cfg_width_i,
	input wire logic [2:0] cmd_o,
	input wire logic cmd_valid_o,
	input wire logic [2:0] bank_o,
	input wire logic [13:0] row_o,
	input wire logic [13:0] col_o,
	input wire logic auto_pre_o,
	input wire logic [7:0] bank_open_o,
	input wire logic [1:0] power_state_o,
	input wire logic odt_on_o,
	input wire logic [13:0] mr_ext_o,
	input wire logic [15:0] wr_bit_en_o,
	input wire logic wr_valid_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// A write command seen on the pins while the device runs normally.
	sequence s_wr_pins;
		!cs_n_pin_i && ras_n_pin_i && !cas_n_pin_i && !we_n_pin_i && power_state_o == 2'h0;
	endsequence
	chk_cs_gate: assert property (cmd_valid_o |-> !$past(cs_n_pin_i, 3))
		else $error("command decoded while chip select was high");
	chk_cmd_code: assert property (cmd_valid_o |-> cmd_o == {$past(ras_n_pin_i, 3), $past(cas_n_pin_i, 3), $past(we_n_pin_i, 3)})
		else $error("decoded command differs from the pins");
	chk_act_row: assert property (cmd_valid_o && cmd_o == 3'h3 |-> row_o == $past(addr_pin_i, 3) && bank_o == $past(ba_pin_i, 3))
		else $error("activate row or bank wrong");
	chk_ap_bit: assert property (cmd_valid_o && cmd_o[2:1] == 2'h2 |-> auto_pre_o == $past(addr_pin_i[10], 3) && !col_o[10])
		else $error("auto precharge bit wrong");
	chk_lmr_sel: assert property (cmd_valid_o && cmd_o == 3'h0 && $past(ba_pin_i[1:0], 3) == 2'h1 |-> mr_ext_o == $past(addr_pin_i, 3))
		else $error("extended mode register not loaded");
	chk_odt_gate: assert property (odt_on_o |-> mr_ext_o[2] || mr_ext_o[6])
		else $error("termination on while disabled");
	chk_pd_quiet: assert property (power_state_o == 2'h2 |-> !cmd_valid_o)
		else $error("command decoded in power-down");
	chk_wr_mask: assert property (s_wr_pins ##1 cfg_width_i == 2'h2 |-> ##3 (wr_valid_o == ($past(dm_pin_i, 3) != 2'h3)) && wr_bit_en_o == {{8{!$past(dm_pin_i[1], 3)}}, {8{!$past(dm_pin_i[0], 3)}}})
		else $error("write byte enables wrong");
endmodule // dcpi_core_assertions
`default_nettype wire

// ===== dcpi_core_bench.sv
// Self-checking bench for the command pin interface core.
`default_nettype none
`include "dcpi_defines.vh"
module dcpi_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, rst_n_i = 0, cke = 1, odt = 0, rd_valid = 0, ce = 1;
	logic [1:0] cfg = 2'h2, m;
	logic [15:0] rd_data = 16'h0, d;
	logic [13:0] op[4];
	logic [2:0] b;
	int err_total = 0, n_compared = 0, cyc = 0;
	wire cs_n, odt_on, wr_v, dqs, dqs_n, dqs_oe, dqs_n_oe, gate;
	wire [2:0] rcw, ba;
	wire [1:0] dm, pst;
	wire [13:0] addr, mr0, mr1, mr2, mr3;
	wire [15:0] dqp, dq, dq_oe, wr_data, wr_en, term;
	wire [7:0] bopen;
	dcpi_ctrl_model dcpi_ctrl_model_i (.clk_i(clk_i), .cs_n_o(cs_n), .rcw_n_o(rcw), .ba_o(ba), .addr_o(addr), .dm_o(dm),
		.dq_o(dqp));
	dcpi_core dcpi_core_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .cfg_width_i(cfg), .cke_pin_i(cke),
		.cs_n_pin_i(cs_n), .ras_n_pin_i(rcw[2]), .cas_n_pin_i(rcw[1]), .we_n_pin_i(rcw[0]), .odt_pin_i(odt),
		.ba_pin_i(ba), .addr_pin_i(addr), .dm_pin_i(dm), .dq_pin_i(dqp), .rd_data_i(rd_data), .rd_valid_i(rd_valid),
		.dq_o(dq), .dq_oe_o(dq_oe), .dqs_o(dqs), .dqs_n_o(dqs_n), .dqs_oe_o(dqs_oe), .dqs_n_oe_o(dqs_n_oe),
		.cmd_o(), .cmd_valid_o(), .bank_o(), .row_o(), .col_o(), .auto_pre_o(), .bank_open_o(bopen),
		.power_state_o(pst), .clk_gate_en_o(gate),
		.odt_on_o(odt_on), .term_en_o(term), .wr_data_o(wr_data), .wr_bit_en_o(wr_en), .wr_valid_o(wr_v),
		.mr_base_o(mr0), .mr_ext_o(mr1), .mr_ext2_o(mr2), .mr_ext3_o(mr3));
	// Clock of 8 ns and a cycle ceiling that cuts a hang short.
	always #4 clk_i = ~clk_i;
	always @(posedge clk_i)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			err_total++;
			stop_test;
		end
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [2:0] c, input logic [2:0] bk, input logic [13:0] a);
		dcpi_ctrl_model_i.send(c, bk, a, 16'h0, 2'h0, 1'b0);
		wt(2);
	endtask
	// Byte enables kept after the mask and the configured width.
	function automatic logic [15:0] exp_en(input logic [1:0] mk, input logic [1:0] w);
		logic [15:0] v;
		v = {{8{~mk[1]}}, {8{~mk[0]}}};
		return (w == `DCPI_CFG_X4) ? v & 16'h000F : (w == `DCPI_CFG_X8) ? v & 16'h00FF : v;
	endfunction
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Main sequence of tests.
	initial
	begin
		void'($urandom(32'h9e9d8648));
		wt(3);
		rst_n_i = 1;
		// The registered clock enable must read high before the first command is decoded.
		wt(2);
		for (int i = 0; i < 4; i++)
		begin
			op[i] = 14'($urandom);
			op[1][2] = 1'b1;
			cmd(`DCPI_CMD_LMR, i[2:0], op[i]);
		end
		chk({2'h0, mr0}, {2'h0, op[0]});
		chk({2'h0, mr1}, {2'h0, op[1]});
		chk({2'h0, mr2}, {2'h0, op[2]});
		chk({2'h0, mr3}, {2'h0, op[3]});
		odt = 1;
		wt(5);
		chk({15'h0000, odt_on}, 16'h0001);
		chk(term, exp_en(2'h0, cfg));
		odt = 0;
		cmd(`DCPI_CMD_LMR, 3'h1, 14'h0000);
		odt = 1;
		wt(5);
		chk({15'h0000, odt_on}, 16'h0000);
		chk(term, 16'h0000);
		odt = 0;
		$display("mode and termination test done");
		b = 3'($urandom);
		dcpi_ctrl_model_i.send(`DCPI_CMD_ACT, b, 14'($urandom), 16'h0000, 2'h0, 1'b1);
		wt(3);
		chk({8'h00, bopen}, 16'h0000);
		cmd(`DCPI_CMD_ACT, b, 14'($urandom));
		chk({8'h00, bopen}, 16'h0001 << b);
		// With the clock enable low the core holds its state and the command is lost.
		ce = 0;
		cmd(`DCPI_CMD_ACT, b ^ 3'h4, 14'h0000);
		ce = 1;
		chk({8'h00, bopen}, 16'h0001 << b);
		for (int w = 0; w < 4; w++)
		begin
			cfg = (w == 3) ? 2'h2 : w[1:0];
			d = 16'($urandom);
			m = (w == 3) ? 2'h1 : 2'($urandom);
			dcpi_ctrl_model_i.send(`DCPI_CMD_WR, b, 14'($urandom), d, m, 1'b0);
			for (int k = 0; k < 8 && wr_v !== 1'b1; k++)
				wt(1);
			chk({15'h0000, wr_v}, {15'h0000, (exp_en(m, cfg) != 16'h0000)});
			chk(wr_en, exp_en(m, cfg));
			chk(wr_data & exp_en(m, cfg), d & exp_en(m, cfg));
		end
		rd_data = 16'($urandom);
		rd_valid = 1;
		wt(1);
		rd_valid = 0;
		chk(dq, rd_data);
		chk(dq_oe, 16'hFFFF);
		// Strobe high, complement low, both driven since the extended register enables the complement.
		chk({12'h000, dqs, dqs_n, dqs_oe, dqs_n_oe}, 16'h000B);
		$display("access test done");
		cke = 0;
		wt(6);
		chk({14'h0000, pst}, {14'h0000, `DCPI_PW_ACT_PD});
		chk({15'h0000, gate}, 16'h0000);
		// Commands are refused while the receivers are off.
		cmd(`DCPI_CMD_ACT, b ^ 3'h2, 14'h0000);
		chk({8'h00, bopen}, 16'h0001 << b);
		cke = 1;
		wt(6);
		chk({15'h0000, gate}, 16'h0001);
		cmd(`DCPI_CMD_PRE, b, 14'h0000);
		chk({8'h00, bopen}, 16'h0000);
		cmd(`DCPI_CMD_ACT, b, 14'h0000);
		cmd(`DCPI_CMD_ACT, b ^ 3'h1, 14'h0000);
		cmd(`DCPI_CMD_PRE, b ^ 3'h2, 14'h0400);
		wt(2);
		chk({8'h00, bopen}, 16'h0000);
		cke = 0;
		wt(6);
		chk({14'h0000, pst}, {14'h0000, `DCPI_PW_PRE_PD});
		cke = 1;
		wt(6);
		chk({14'h0000, pst}, {14'h0000, `DCPI_PW_NORMAL});
		// A refresh issued as the clock enable falls, all banks idle, enters self refresh.
		cke = 0;
		cmd(`DCPI_CMD_REF, 3'h0, 14'h0000);
		wt(2);
		chk({14'h0000, pst}, {14'h0000, `DCPI_PW_SELF});
		cke = 1;
		wt(1);
		chk({14'h0000, pst}, {14'h0000, `DCPI_PW_NORMAL});
		$display("power test done");
		stop_test;
	end
endmodule // dcpi_core_bench
bind dcpi_core dcpi_core_assertions dcpi_core_assertions_i (.*);
`default_nettype wire

// ===== dcpi_ctrl_model.sv
// Memory controller model driving command, address, mask and write data pins.
`default_nettype none
module dcpi_ctrl_model (
	input wire logic clk_i,
	output logic cs_n_o = 1'b1,
	output logic [2:0] rcw_n_o = 3'h7,
	output logic [2:0] ba_o = 3'h0,
	output logic [13:0] addr_o = 14'h0,
	output logic [1:0] dm_o = 2'h0,
	output logic [15:0] dq_o = 16'h0
);
	// Issue one command, give its data beat next cycle with the command lines deasserted, then invert the data and mask lines.
	task automatic send(input logic [2:0] c, input logic [2:0] b, input logic [13:0] a, input logic [15:0] d,
		input logic [1:0] m, input logic cs);
		rcw_n_o = c;
		cs_n_o = cs;
		ba_o = b;
		addr_o = a;
		@(posedge clk_i) #1;
		cs_n_o = 1'b1;
		rcw_n_o = 3'h7;
		ba_o = ~b;
		addr_o = ~a;
		dq_o = d;
		dm_o = m;
		@(posedge clk_i) #1;
		dq_o = ~d;
		dm_o = ~m;
	endtask
endmodule // dcpi_ctrl_model
`default_nettype wire

// ===== dcpi_defines.vh
// Constants for the DDR2 command pin interface block.
`ifndef DCPI_DEFINES_VH
`define DCPI_DEFINES_VH
`define DCPI_ADDR_W 14
`define DCPI_BANK_W 3
`define DCPI_NBANK 8
`define DCPI_DQ_W 16
`define DCPI_AP_BIT 10
`define DCPI_CMD_LMR 3'h0
`define DCPI_CMD_REF 3'h1
`define DCPI_CMD_PRE 3'h2
`define DCPI_CMD_ACT 3'h3
`define DCPI_CMD_WR 3'h4
`define DCPI_CMD_RD 3'h5
`define DCPI_CMD_BST 3'h6
`define DCPI_CMD_NOP 3'h7
`define DCPI_MR_BASE 2'h0
`define DCPI_MR_EXT 2'h1
`define DCPI_MR_EXT2 2'h2
`define DCPI_MR_EXT3 2'h3
`define DCPI_EMR_RTT_LO 2
`define DCPI_EMR_RTT_HI 6
`define DCPI_EMR_DQSN_BIT 10
`define DCPI_CFG_X4 2'h0
`define DCPI_CFG_X8 2'h1
`define DCPI_CFG_X16 2'h2
`define DCPI_PW_NORMAL 2'h0
`define DCPI_PW_PRE_PD 2'h1
`define DCPI_PW_ACT_PD 2'h2
`define DCPI_PW_SELF 2'h3
`endif

// ===== dcpi_sync2.v
// Two-flop synchroniser for pin inputs, one per bit.
`default_nettype none
module dcpi_sync2 #(
	parameter W = 1
) (
	input wire clk_i,
	input wire rst_n_i,
	input wire [W-1:0] d_i,
	output wire [W-1:0] q_o
);
	reg [W-1:0] meta_r;
	reg [W-1:0] sync_r;
	// Capture then settle; only the second stage is visible.
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_r <= {W{1'b0}};
			sync_r <= {W{1'b0}};
		end
		else
		begin
			meta_r <= d_i;
			sync_r <= meta_r;
		end
	end
	assign q_o = sync_r;
endmodule // dcpi_sync2
`default_nettype wire
